// File: ufw_consts.svh
// constants of the fifo window and setup buffer block
// assumes inclusion by bare name from the package and the modules
`ifndef UFW_CONSTS_SVH
`define UFW_CONSTS_SVH

// register offsets on the register port
`define UFW_OFS_BYTE_COUNT 8'h00_F2
`define UFW_OFS_BASE_HIGH 8'h00_F3
`define UFW_OFS_BASE_LOW 8'h00_F4
`define UFW_OFS_SETUP_INDEX 8'h00_F5
`define UFW_OFS_SETUP_VALUE 8'h00_F6

// field positions
`define UFW_COUNT_MSB 6
`define UFW_COUNT_LSB 0
`define UFW_BASE_LOW_MSB 7
`define UFW_BASE_LOW_LSB 6
`define UFW_INDEX_MSB 2
`define UFW_INDEX_LSB 0

// reset values
`define UFW_RST_BYTE 8'h00_00
`define UFW_RST_COUNT 7'h00_00
`define UFW_RST_INDEX 3'h0_0

// sizes
`define UFW_FIFO_BYTES 7'h00_40
`define UFW_NUM_EP 10
`define UFW_NUM_EP_LAST 4'h0_9
`define UFW_SETUP_BYTES 8

`endif

// File: ufw_pkg.sv
// types of the fifo window and setup buffer block
// assumes ufw_consts.svh is on the include path
`include "ufw_consts.svh"

package ufw_pkg;

  typedef logic [7:0] ufw_byte_t;
  typedef logic [6:0] ufw_count_t;
  typedef logic [5:0] ufw_offset_t;
  typedef logic [3:0] ufw_ep_t;
  typedef logic [2:0] ufw_index_t;
  // flat byte address: direction, endpoint, offset
  typedef logic [10:0] ufw_mem_addr_t;

  typedef enum logic [0:0] {
    UFW_DIR_OUT = 1'b0,
    UFW_DIR_IN = 1'b1
  } ufw_dir_t;

endpackage : ufw_pkg

// File: ufw_mem_if.sv
// two-port link between the top and the fifo memory
// assumes ufw_pkg is compiled first
`timescale 1ns/100ps
`default_nettype none

interface ufw_mem_if;
  // cpu port
  logic a_en;
  logic a_we;
  ufw_pkg::ufw_mem_addr_t a_addr;
  ufw_pkg::ufw_byte_t a_wdata;
  ufw_pkg::ufw_byte_t a_rdata;
  // serial engine port
  logic b_en;
  logic b_we;
  ufw_pkg::ufw_mem_addr_t b_addr;
  ufw_pkg::ufw_byte_t b_wdata;
  ufw_pkg::ufw_byte_t b_rdata;

  modport ctrl (
    output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
    input a_rdata, b_rdata
  );
  modport mem (
    input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
    output a_rdata, b_rdata
  );
endinterface : ufw_mem_if

`default_nettype wire

// File: ufw_fifo_mem.sv
// endpoint fifo storage, two ports, registered read data
// assumes one clock; enable freezes ports and read registers
`timescale 1ns/100ps
`default_nettype none

module ufw_fifo_mem (
  // clock and enable
  input wire logic i_sys_clk,
  input wire logic i_ce,
  // ports
  ufw_mem_if.mem mif
);

  ufw_pkg::ufw_byte_t mem_q [0:2047];

  // same-address writes on both ports: serial engine port lands last
  always_ff @(posedge i_sys_clk) begin
    if (i_ce) begin
      if (mif.a_en && mif.a_we) begin
        mem_q[mif.a_addr] <= mif.a_wdata;
      end
      if (mif.b_en && mif.b_we) begin
        mem_q[mif.b_addr] <= mif.b_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_ce && mif.a_en && !mif.a_we) begin
      mif.a_rdata <= mem_q[mif.a_addr];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_ce && mif.b_en && !mif.b_we) begin
      mif.b_rdata <= mem_q[mif.b_addr];
    end
  end

endmodule : ufw_fifo_mem

`default_nettype wire

// File: ufw_top.sv
// fifo valid count, fifo window mapping and setup command buffer
// assumes all inputs synchronous to i_sys_clk; endpoint select
// comes from a register outside this block
`timescale 1ns/100ps
`default_nettype none
`include "ufw_consts.svh"

// Overview of operation
// - count write arms selected in fifo
// - out count read gives received bytes
// - seven bit count, bit7 reserved, max 64
// - count follows selected endpoint and direction
// - ten in and ten out fifos share one 64 byte window
// - window accesses go to selected fifo
// - window base aligned, low six bits zero
// - high base byte fully read write
// - low base bits 7:6 rw, rest zero
// - setup packet bytes stored in buffer
// - three bit setup index, bits 7:3 reserved
// - setup value reads indexed buffer byte
// - all registers read zero after reset
// - in busy set on count write till sent
// - out busy while filling, read after clear
module ufw_top (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // endpoint select
  input wire logic [3:0] i_ep_sel,
  input wire logic i_ep_dir_in,
  // external data space
  input wire logic [15:0] i_xd_addr,
  input wire logic [7:0] i_xd_wdata,
  input wire logic i_xd_wr,
  input wire logic i_xd_rd,
  output logic [7:0] o_xd_rdata,
  output logic o_xd_hit,
  // busy flag of selected fifo
  output logic o_fifo_busy,
  // serial engine memory port
  input wire logic [3:0] i_sie_ep,
  input wire logic [5:0] i_sie_off,
  input wire logic i_sie_wr,
  input wire logic [7:0] i_sie_wdata,
  input wire logic i_sie_rd,
  output logic [7:0] o_sie_rdata,
  // serial engine events
  input wire logic i_sie_out_start,
  input wire logic i_sie_out_done,
  input wire logic [6:0] i_sie_out_count,
  input wire logic i_sie_in_done,
  input wire logic i_sie_setup_start,
  input wire logic i_sie_setup_wr,
  input wire logic [7:0] i_sie_setup_data,
  // armed in fifos and the in count of the engine endpoint
  output logic [9:0] o_in_armed,
  output logic [6:0] o_in_count
);

  // window base and setup index
  ufw_pkg::ufw_byte_t base_high_q;
  logic [1:0] base_low_q;
  ufw_pkg::ufw_index_t setup_index_q;
  // per endpoint counts and busy flags
  ufw_pkg::ufw_count_t in_count_q [0:`UFW_NUM_EP-1];
  ufw_pkg::ufw_count_t out_count_q [0:`UFW_NUM_EP-1];
  logic [9:0] in_busy_q;
  logic [9:0] out_busy_q;
  // setup buffer
  ufw_pkg::ufw_byte_t setup_buf_q [0:`UFW_SETUP_BYTES-1];
  ufw_pkg::ufw_index_t setup_ptr_q;
  logic setup_full_q;
  // register port
  ufw_pkg::ufw_byte_t reg_rdata_d;
  // window
  logic xd_hit_d;
  logic xd_rd_q;
  logic sie_rd_q;
  ufw_mem_if mif ();

  // limit a count to the fifo depth
  function automatic ufw_pkg::ufw_count_t clamp_count(
    input logic [6:0] cnt
  );
    if (cnt > `UFW_FIFO_BYTES) begin
      clamp_count = `UFW_FIFO_BYTES;
    end else begin
      clamp_count = cnt;
    end
  endfunction : clamp_count

  // flat memory address of a fifo byte
  function automatic ufw_pkg::ufw_mem_addr_t mem_addr(
    input logic dir_in,
    input logic [3:0] ep,
    input logic [5:0] off
  );
    mem_addr = {dir_in, ep, off};
  endfunction : mem_addr

  // endpoint number in range
  function automatic logic ep_ok(input logic [3:0] ep);
    ep_ok = (ep <= `UFW_NUM_EP_LAST);
  endfunction : ep_ok

  function automatic logic is_write(input logic [7:0] ofs);
    is_write = i_reg_wr && (i_reg_addr == ofs);
  endfunction : is_write

  wire logic sel_ok = ep_ok(i_ep_sel);
  logic count_wr;
  wire logic sie_ok = ep_ok(i_sie_ep);

  // count write for a valid endpoint; strobe is read inside the function
  always_comb begin
    count_wr = is_write(`UFW_OFS_BYTE_COUNT) && sel_ok;
  end

  // window hit: upper ten address bits match the base
  always_comb begin
    xd_hit_d = (i_xd_addr[15:6] == {base_high_q, base_low_q}) && sel_ok;
  end

  // base high byte
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      base_high_q <= `UFW_RST_BYTE;
    end else if (i_ce && is_write(`UFW_OFS_BASE_HIGH)) begin
      base_high_q <= i_reg_wdata;
    end
  end

  // base low: only bits 7:6 are stored
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      base_low_q <= 2'h0_0;
    end else if (i_ce && is_write(`UFW_OFS_BASE_LOW)) begin
      base_low_q <= i_reg_wdata[`UFW_BASE_LOW_MSB:`UFW_BASE_LOW_LSB];
    end
  end

  // setup index
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      setup_index_q <= `UFW_RST_INDEX;
    end else if (i_ce && is_write(`UFW_OFS_SETUP_INDEX)) begin
      setup_index_q <= i_reg_wdata[`UFW_INDEX_MSB:`UFW_INDEX_LSB];
    end
  end

  // in counts: written by cpu for the selected endpoint
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < `UFW_NUM_EP; i++) begin
        in_count_q[i] <= `UFW_RST_COUNT;
      end
    end else if (i_ce && count_wr && i_ep_dir_in) begin
      in_count_q[i_ep_sel] <= clamp_count(i_reg_wdata[6:0]);
    end
  end

  // out counts: loaded at the end of each out packet
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < `UFW_NUM_EP; i++) begin
        out_count_q[i] <= `UFW_RST_COUNT;
      end
    end else if (i_ce && i_sie_out_done && sie_ok) begin
      out_count_q[i_sie_ep] <= clamp_count(i_sie_out_count);
    end
  end

  // in busy: arming wins over a same-cycle completion
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_busy_q <= 10'h0_00;
    end else if (i_ce) begin
      for (int i = 0; i < `UFW_NUM_EP; i++) begin
        if (count_wr && i_ep_dir_in && (i_ep_sel == 4'(i))) begin
          in_busy_q[i] <= 1'b1;
        end else if (i_sie_in_done && (i_sie_ep == 4'(i))) begin
          in_busy_q[i] <= 1'b0;
        end
      end
    end
  end

  // out busy: set while the engine fills, cleared at packet end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_busy_q <= 10'h0_00;
    end else if (i_ce) begin
      for (int i = 0; i < `UFW_NUM_EP; i++) begin
        if (i_sie_out_start && (i_sie_ep == 4'(i))) begin
          out_busy_q[i] <= 1'b1;
        end else if (i_sie_out_done && (i_sie_ep == 4'(i))) begin
          out_busy_q[i] <= 1'b0;
        end
      end
    end
  end

  // setup buffer fill pointer; a new packet restarts it
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      setup_ptr_q <= `UFW_RST_INDEX;
      setup_full_q <= 1'b0;
    end else if (i_ce) begin
      if (i_sie_setup_start) begin
        setup_ptr_q <= `UFW_RST_INDEX;
        setup_full_q <= 1'b0;
      end else if (i_sie_setup_wr && !setup_full_q) begin
        setup_ptr_q <= setup_ptr_q + 3'h0_1;
        setup_full_q <= (setup_ptr_q == 3'h0_7);
      end
    end
  end

  // setup buffer bytes; extra bytes past eight are dropped
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < `UFW_SETUP_BYTES; i++) begin
        setup_buf_q[i] <= `UFW_RST_BYTE;
      end
    end else if (i_ce && i_sie_setup_wr && !setup_full_q &&
                 !i_sie_setup_start) begin
      setup_buf_q[setup_ptr_q] <= i_sie_setup_data;
    end
  end

  // register read mux
  always_comb begin
    reg_rdata_d = `UFW_RST_BYTE;
    case (i_reg_addr)
      `UFW_OFS_BYTE_COUNT: begin
        if (sel_ok && i_ep_dir_in) begin
          reg_rdata_d = {1'b0, in_count_q[i_ep_sel]};
        end else if (sel_ok) begin
          reg_rdata_d = {1'b0, out_count_q[i_ep_sel]};
        end
      end
      `UFW_OFS_BASE_HIGH: begin
        reg_rdata_d = base_high_q;
      end
      `UFW_OFS_BASE_LOW: begin
        reg_rdata_d = {base_low_q, 6'h0_0};
      end
      `UFW_OFS_SETUP_INDEX: begin
        reg_rdata_d = {5'h0_0, setup_index_q};
      end
      `UFW_OFS_SETUP_VALUE: begin
        reg_rdata_d = setup_buf_q[setup_index_q];
      end
      default: begin
        reg_rdata_d = `UFW_RST_BYTE;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= `UFW_RST_BYTE;
    end else if (i_ce) begin
      if (i_reg_rd) begin
        o_reg_rdata <= reg_rdata_d;
      end else begin
        o_reg_rdata <= `UFW_RST_BYTE;
      end
    end
  end

  // cpu side of the memory: window decode to selected fifo
  always_comb begin
    mif.a_en = xd_hit_d && (i_xd_wr || i_xd_rd);
    mif.a_we = i_xd_wr;
    mif.a_addr = mem_addr(i_ep_dir_in, i_ep_sel, i_xd_addr[5:0]);
    mif.a_wdata = i_xd_wdata;
  end

  // engine side: writes land in out fifos, reads come from in fifos
  always_comb begin
    mif.b_en = sie_ok && (i_sie_wr || i_sie_rd);
    mif.b_we = i_sie_wr;
    mif.b_addr = mem_addr(!i_sie_wr, i_sie_ep, i_sie_off);
    mif.b_wdata = i_sie_wdata;
  end

  ufw_fifo_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .i_ce (i_ce),
    .mif (mif.mem)
  );

  // window read strobes delayed to match memory latency
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      xd_rd_q <= 1'b0;
      sie_rd_q <= 1'b0;
    end else if (i_ce) begin
      xd_rd_q <= xd_hit_d && i_xd_rd && !i_xd_wr;
      sie_rd_q <= sie_ok && i_sie_rd && !i_sie_wr;
    end
  end

  // window answer: hit one cycle after the access, read data two cycles after the read
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_xd_hit <= 1'b0;
      o_xd_rdata <= `UFW_RST_BYTE;
      o_sie_rdata <= `UFW_RST_BYTE;
    end else if (i_ce) begin
      o_xd_hit <= xd_hit_d && (i_xd_rd || i_xd_wr);
      o_xd_rdata <= xd_rd_q ? mif.a_rdata : `UFW_RST_BYTE;
      o_sie_rdata <= sie_rd_q ? mif.b_rdata : `UFW_RST_BYTE;
    end
  end

  // status outputs
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fifo_busy <= 1'b0;
      o_in_armed <= 10'h0_00;
      o_in_count <= `UFW_RST_COUNT;
    end else if (i_ce) begin
      o_fifo_busy <= sel_ok &&
        (i_ep_dir_in ? in_busy_q[i_ep_sel] : out_busy_q[i_ep_sel]);
      o_in_armed <= in_busy_q;
      o_in_count <= sie_ok ? in_count_q[i_sie_ep] : `UFW_RST_COUNT;
    end
  end

endmodule : ufw_top

`default_nettype wire

// File: ufw_top_sva.sv
// assertions on the ports of ufw_top, bound at the foot
// assumes i_ce is held high by the surroundings
`timescale 1ns/100ps
`default_nettype none
module ufw_top_sva (
  // clock, reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // cpu side
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [3:0] i_ep_sel,
  input wire logic i_ep_dir_in,
  input wire logic [15:0] i_xd_addr,
  input wire logic i_xd_wr,
  input wire logic i_xd_rd,
  input wire logic o_xd_hit,
  input wire logic o_fifo_busy,
  // engine side
  input wire logic [3:0] i_sie_ep,
  input wire logic i_sie_out_start,
  input wire logic i_sie_in_done,
  input wire logic [9:0] o_in_armed
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  logic [9:0] base_q;
  logic hit;
  assign hit = (i_xd_rd || i_xd_wr) && i_ep_sel <= 4'h9
    && i_xd_addr[15:6] == base_q;
  // shadow of the window base
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      base_q <= '0;
    end else if (i_reg_wr && i_reg_addr == 8'hF3) begin
      base_q[9:2] <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == 8'hF4) begin
      base_q[1:0] <= i_reg_wdata[7:6];
    end
  end
  property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
  property p_cnt;
    i_reg_rd && i_reg_addr == 8'hF2 |=> o_reg_rdata <= 8'h40;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count range");
  property p_low;
    i_reg_rd && i_reg_addr == 8'hF4 |=> o_reg_rdata == {base_q[1:0], 6'h00};
  endproperty
  a_low: assert property (p_low) else $error("base low");
  property p_hit; hit |=> o_xd_hit; endproperty
  a_hit: assert property (p_hit) else $error("window hit");
  property p_miss; !hit |=> !o_xd_hit; endproperty
  a_miss: assert property (p_miss) else $error("window miss");
  property p_arm;
    i_reg_wr && i_reg_addr == 8'hF2 && i_ep_dir_in && i_ep_sel <= 4'h9
      ##1 !i_sie_in_done |=> o_in_armed[$past(i_ep_sel, 2)];
  endproperty
  a_arm: assert property (p_arm) else $error("not armed");
  property p_disarm;
    |($past(o_in_armed) & ~o_in_armed) |-> $past(i_sie_in_done, 2);
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm");
  property p_out_busy;
    i_sie_out_start && i_sie_ep == i_ep_sel && !i_ep_dir_in
      ##1 $stable(i_ep_sel) && !i_ep_dir_in |=> o_fifo_busy;
  endproperty
  a_out_busy: assert property (p_out_busy) else $error("out busy");
endmodule : ufw_top_sva

bind ufw_top ufw_top_sva ufw_top_sva_u (.*);
`default_nettype wire

// File: ufw_sie_model.sv
// engine and host stand-in driving the engine ports
// assumes tasks are called just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module ufw_sie_model (
  // clock
  input wire logic i_sys_clk,
  // engine ports of the block
  output logic [3:0] o_ep,
  output logic [5:0] o_off,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd,
  output logic o_out_start,
  output logic o_out_done,
  output logic [6:0] o_out_count,
  output logic o_in_done,
  output logic o_setup_start,
  output logic o_setup_wr,
  output logic [7:0] o_setup_data
);
  initial begin
    {o_ep, o_off, o_wr, o_rd, o_wdata, o_out_start, o_out_done} = '0;
    {o_out_count, o_in_done, o_setup_start, o_setup_wr, o_setup_data} = '0;
  end
  task automatic setup_pkt(input logic [63:0] b);
    o_setup_start <= 1'b1;
    @(posedge i_sys_clk);
    o_setup_start <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      o_setup_wr <= 1'b1;
      o_setup_data <= b[8*i +: 8];
      @(posedge i_sys_clk);
    end
    o_setup_wr <= 1'b0;
    o_setup_data <= ~b[63:56];
  endtask : setup_pkt
  // bytes b0, b0+1, ...; gap idle cycles after each byte
  task automatic out_pkt(input logic [3:0] ep, input logic [6:0] n,
    input logic [7:0] b0, input int gap);
    o_ep <= ep;
    o_out_start <= 1'b1;
    @(posedge i_sys_clk);
    o_out_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_wr <= 1'b1;
      o_off <= i[5:0];
      o_wdata <= b0 + i[7:0];
      @(posedge i_sys_clk);
      if (gap > 0) begin
        o_wr <= 1'b0;
        o_wdata <= ~o_wdata;
        repeat (gap) @(posedge i_sys_clk);
      end
    end
    if (gap == 0) o_wr <= 1'b0;
    o_out_done <= 1'b1;
    o_out_count <= n;
    @(posedge i_sys_clk);
    o_out_done <= 1'b0;
    o_out_count <= ~n;
  endtask : out_pkt
  // engine fetch of n bytes from the in fifo of ep, one per cycle
  task automatic in_read(input logic [3:0] ep, input logic [6:0] n);
    o_ep <= ep;
    for (int i = 0; i < n; i++) begin
      o_rd <= 1'b1;
      o_off <= i[5:0];
      @(posedge i_sys_clk);
    end
    o_rd <= 1'b0;
  endtask : in_read
  task automatic in_send(input logic [3:0] ep);
    o_ep <= ep;
    o_in_done <= 1'b1;
    @(posedge i_sys_clk);
    o_in_done <= 1'b0;
  endtask : in_send
endmodule : ufw_sie_model
`default_nettype wire

// File: test_usb_fifo_window_and_setup_buffer.sv
// self-checking bench of ufw_top with the engine stand-in
// assumes ufw_top, ufw_top_sva and ufw_sie_model compiled first
`timescale 1ns/100ps
`default_nettype none
module test_usb_fifo_window_and_setup_buffer;
  logic i_sys_clk, i_nrst, i_ce, i_reg_wr, i_reg_rd, i_ep_dir_in, i_xd_wr;
  logic i_xd_rd, i_sie_rd, o_xd_hit, o_fifo_busy, i_sie_wr, i_sie_out_start;
  logic i_sie_out_done, i_sie_in_done, i_sie_setup_start, i_sie_setup_wr;
  logic [3:0] i_ep_sel, i_sie_ep;
  logic [5:0] i_sie_off;
  logic [6:0] i_sie_out_count, o_in_count;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_xd_wdata, o_xd_rdata;
  logic [7:0] i_sie_wdata, o_sie_rdata, i_sie_setup_data;
  logic [9:0] o_in_armed;
  logic [15:0] i_xd_addr, base;
  logic [7:0] rq[$], sq[$];
  logic [8:0] xq[$];
  logic rd1, xr1, xr2, h_q, sr1, sr2;
  int n_mismatch, n_tests, cyc;

  ufw_top dut_u (.*);
  ufw_sie_model sie_u (
    .i_sys_clk, .o_ep(i_sie_ep), .o_off(i_sie_off), .o_wr(i_sie_wr),
    .o_wdata(i_sie_wdata), .o_rd(i_sie_rd), .o_out_start(i_sie_out_start),
    .o_out_done(i_sie_out_done), .o_out_count(i_sie_out_count),
    .o_in_done(i_sie_in_done), .o_setup_start(i_sie_setup_start),
    .o_setup_wr(i_sie_setup_wr), .o_setup_data(i_sie_setup_data)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // one cycle: 0 idle, 1/2 register write/read, 3/4 window write/read
  task automatic acc(input int k, input logic [15:0] a, input logic [7:0] d);
    i_reg_wr <= k == 1;
    i_reg_rd <= k == 2;
    i_xd_wr <= k == 3;
    i_xd_rd <= k == 4;
    i_reg_addr <= a[7:0];
    i_xd_addr <= a;
    i_reg_wdata <= d;
    i_xd_wdata <= d;
    @(posedge i_sys_clk);
  endtask : acc

  task automatic rd_reg(input logic [7:0] a, e);
    rq.push_back(e);
    acc(2, {8'h00, a}, ~e);
  endtask : rd_reg

  task automatic rd_xd(input logic [15:0] a, input logic [8:0] e);
    xq.push_back(e);
    acc(4, a, ~e[7:0]);
  endtask : rd_xd

  // register data one cycle after the read, window data two
  always @(posedge i_sys_clk) begin
    if (rd1) chk("reg", {8'h00, rq.pop_front()}, {8'h00, o_reg_rdata});
    if (xr2) chk("xd", {7'h00, xq.pop_front()}, {7'h00, h_q, o_xd_rdata});
    if (sr2) chk("sie", {8'h00, sq.pop_front()}, {8'h00, o_sie_rdata});
    sr1 <= i_sie_rd;
    sr2 <= sr1;
    rd1 <= i_reg_rd;
    xr1 <= i_xd_rd;
    xr2 <= xr1;
    h_q <= o_xd_hit;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    logic [63:0] sb;
    logic [7:0] h, b0;
    logic [6:0] n;
    logic [3:0] ep;
    {i_sys_clk, i_nrst, i_reg_wr, i_reg_rd, i_ep_dir_in, sr1, sr2} = '0;
    {i_xd_wr, i_xd_rd, rd1, xr1, xr2, h_q, i_ep_sel, i_reg_addr} = '0;
    {i_reg_wdata, i_xd_wdata, i_xd_addr} = '0;
    i_ce = 1'b1;
    void'($urandom(32'h8a99));
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    acc(0, 16'h0000, 8'h00);
    for (int i = 0; i < 6; i++) rd_reg(8'hF2 + i[7:0], 8'h00);
    h = 8'($urandom());
    b0 = 8'($urandom());
    acc(1, 16'h00F3, h);
    acc(1, 16'h00F4, b0 | 8'h3F);
    rd_reg(8'hF3, h);
    rd_reg(8'hF4, b0 & 8'hC0);
    base = {h, b0[7:6], 6'h00};
    acc(1, 16'h00F5, 8'hFF);
    rd_reg(8'hF5, 8'h07);
    acc(0, 16'h0000, 8'h00);
    sb = {$urandom(), $urandom()};
    sie_u.setup_pkt(sb);
    acc(1, 16'h00F6, ~sb[7:0]);
    for (int i = 0; i < 8; i++) begin
      acc(1, 16'h00F5, i[7:0]);
      rd_reg(8'hF6, sb[8*i +: 8]);
    end
    ep = 4'($urandom_range(9));
    n = 7'($urandom_range(63, 1));
    i_ep_sel <= ep;
    i_ep_dir_in <= 1'b1;
    for (int i = 0; i < 4; i++) acc(3, base + i[15:0], b0 + i[7:0]);
    for (int i = 0; i < 4; i++) rd_xd(base + i[15:0], {1'b1, b0 + i[7:0]});
    acc(0, 16'h0000, 8'h00);
    for (int i = 0; i < 4; i++) sq.push_back(b0 + i[7:0]);
    sie_u.in_read(ep, 7'h04);
    rd_xd(base + 16'h0040, 9'h000);
    acc(1, 16'h00F2, {1'b0, n});
    repeat (2) acc(0, 16'h0000, 8'h00);
    chk("armed", {6'h00, 10'h001 << ep}, {6'h00, o_in_armed});
    rd_reg(8'hF2, {1'b0, n});
    acc(1, 16'h00F2, 8'h7F);
    rd_reg(8'hF2, 8'h40);
    i_ep_sel <= 4'hA;
    rd_xd(base, 9'h000);
    rd_reg(8'hF2, 8'h00);
    i_ep_sel <= ep;
    acc(0, 16'h0000, 8'h00);
    sie_u.in_send(ep);
    repeat (2) acc(0, 16'h0000, 8'h00);
    chk("armed", 16'h0000, {6'h00, o_in_armed});
    chk("in_count", 16'h0040, {9'h000, o_in_count});
    i_ep_dir_in <= 1'b0;
    for (int g = 0; g < 3; g += 2) begin
      n = 7'($urandom_range(64, 1));
      b0 = 8'($urandom());
      acc(0, 16'h0000, 8'h00);
      sie_u.out_pkt(ep, n, b0, g);
      repeat (2) acc(0, 16'h0000, 8'h00);
      chk("busy", 16'h0000, {15'h0000, o_fifo_busy});
      rd_reg(8'hF2, {1'b0, n});
      for (int i = 0; i < n; i++) rd_xd(base + i[15:0], {1'b1, b0 + i[7:0]});
    end
    repeat (3) acc(0, 16'h0000, 8'h00);
    results();
  end
endmodule : test_usb_fifo_window_and_setup_buffer
`default_nettype wire
